// ===== include/idec_consts.svh
`ifndef IDEC_CONSTS_SVH
`define IDEC_CONSTS_SVH
`define OP_NOP 16'h0000
`define OP_RET 16'h0040
`define OP_INTERRUPT_RETURN 16'h0060
`define OP_TABLE_READ_LOW 16'h0050
`define OP_TABLE_READ_HIGH 16'h0058
`define OP_CLEAR_WORKING_OP 16'h0140
`define OP_SLEEP 16'h1e03
`define OP_WATCHDOG_CLEAR_OP 16'h1e04
`define LIT_RETURN_WITH_LITERAL 8'h18
`define LIT_LOAD_LITERAL_OP 8'h19
`define LIT_OR_LITERAL_OP 8'h1a
`define LIT_AND_LITERAL_OP 8'h1b
`define LIT_ADD_LITERAL_OP 8'h1c
`define LIT_XOR_LITERAL_OP 8'h1d
`define LIT_LITERAL_SUBTRACT_OP 8'h1f
`define BY_MOVWX 5'h01
`define BY_CLEAR_REGISTER_OP 5'h03
`define BY_SUB 4'h2
`define BY_DEC 4'h3
`define BY_IOR 4'h4
`define BY_AND 4'h5
`define BY_XOR 4'h6
`define BY_ADD 4'h7
`define BY_MOV 4'h8
`define BY_COM 4'h9
`define BY_INC 4'ha
`define BY_DECSZ 4'hb
`define BY_RRX 4'hc
`define BY_RLX 4'hd
`define BY_SWAP 4'he
`define BY_INCSZ 4'hf
`define BIT_CLR 2'h0
`define BIT_SET 2'h1
`define BIT_TSC 2'h2
`define BIT_TSS 2'h3
`endif

// ===== include/idec_pkg.sv
package idec_pkg;
  typedef enum logic [2:0] {
    st_exec = 3'b001,
    st_flush = 3'b010,
    st_table = 3'b100
  } state_t;
endpackage

// ===== rtl/instruction_decoder.sv
// Function
// RQ1: Long branch loads 13-bit target into PC, two cycles.
// RQ2: Long call pushes next address, loads 13-bit target, two cycles.
// RQ3: OR literal into W, zero flag only, one cycle.
// RQ4: Load literal into W, flags untouched, one cycle.
// RQ5: Returns pop stack into PC in two cycles; literal variant loads W.
// RQ6: Interrupt return also sets global interrupt enable.
// RQ7: Sleep requests power-down, one cycle, updates timeout/powerdown flags.
// RQ8: Literal subtract puts k minus W in W, sets C, DC, Z.
// RQ9: Table reads load W with high or low ROM byte, two cycles.
// RQ10: Table pointer is high register above low byte.
// RQ11: XOR literal into W, zero flag only, one cycle.
// RQ12: Add literal to W, sets C, DC, Z.
// RQ13: Register add writes sum to W or file by destination bit.
// RQ14: AND literal into W, zero flag only, one cycle.
// RQ15: Register AND/OR route by destination, zero flag only.
// RQ16: Bit clear/set force selected bit, no flags, one cycle.
// RQ17: Skip-if-clear discards next instruction when bit is 0.
// RQ18: Skip-if-set discards next instruction when bit is 1.
// RQ19: Clear register and clear W write zero and set Z.
// RQ20: Watchdog clear resets counter, updates timeout/powerdown flags.
// RQ21: Complement writes inverted file value by destination, Z only.
// RQ22: Decrement and increment write f minus/plus one, Z only.
// RQ23: Skip variants store result, no flags, skip when zero.
// RQ24: File address is instruction bits 15:14 above bits 6:0.
// RQ25: All-zero word is a one-cycle no-operation; cancels issue it too.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "idec_consts.svh"
module instruction_decoder #(
  parameter int PC_W = 13,
  parameter int TP_HIGH_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] instr_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic [15:0] rom_data_i,
  input wire logic [PC_W-1:0] pc_i,
  input wire logic [PC_W-1:0] stack_top_i,
  input wire logic [7:0] table_pointer_low_i,
  input wire logic [TP_HIGH_W-1:0] table_pointer_high_i,
  input wire logic carry_i,
  output logic [8:0] file_addr_o,
  output logic file_we_o,
  output logic [7:0] file_wdata_o,
  output logic [7:0] working_o,
  output logic carry_o,
  output logic digit_carry_flag_o,
  output logic zero_o,
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_target_o,
  output logic push_o,
  output logic [PC_W-1:0] push_data_o,
  output logic pop_o,
  output logic global_interrupt_enable_set_o,
  output logic sleep_req_o,
  output logic watchdog_clear_o,
  output logic timeout_flag_o,
  output logic powerdown_flag_o,
  output logic rom_read_o,
  output logic [15:0] rom_addr_o,
  output logic busy_o
);

  initial begin
    if (PC_W != 13 || TP_HIGH_W < 1 || TP_HIGH_W > 8) begin
      $error("instruction_decoder: unsupported widths");
    end
  end

  // ==========================================================
  // Field decode
  // ==========================================================
  idec_pkg::state_t state;
  idec_pkg::state_t next_state;
  logic tab_high;
  logic [15:0] ins;
  logic [7:0] lit;
  logic [7:0] hi;
  logic [8:0] faddr;
  logic dest;
  logic [2:0] bsel;
  logic [7:0] f;
  logic [7:0] w;
  wire exec = (state == idec_pkg::st_exec);
  // Cancelled slot behaves as the all-zero word
  assign ins = exec ? instr_i : `OP_NOP; // see RQ25
  assign lit = ins[7:0];
  assign hi = ins[15:8];
  assign faddr = {ins[15:14], ins[6:0]}; // see RQ24
  assign dest = ins[7];
  assign bsel = ins[9:7];
  assign f = file_rdata_i;
  wire is_ctl = (ins[13] == 1'b1) && (ins[12] == 1'b0);
  wire is_bit = (ins[13:12] == 2'b11);
  wire is_lit = (hi[7:3] == 5'h03);
  // Bit 7 set marks the move and clear file forms
  wire is_sys = (ins[15:9] == 7'h00) && !ins[7];
  wire is_byte = (ins[13:12] == 2'b00) && !is_lit && !is_sys;
  wire [3:0] bop = ins[11:8];
  wire [1:0] bitop = ins[11:10];
  wire is_goto = is_ctl && ins[11]; // see RQ1
  wire is_call = is_ctl && !ins[11]; // see RQ2
  wire is_ret = (ins == `OP_RET);
  wire is_interrupt_return = (ins == `OP_INTERRUPT_RETURN); // see RQ6
  wire is_return_with_literal = is_lit && (hi == `LIT_RETURN_WITH_LITERAL);
  wire is_tabl = (ins == `OP_TABLE_READ_LOW);
  wire is_tabh = (ins == `OP_TABLE_READ_HIGH);
  wire is_clear_working_op = (ins == `OP_CLEAR_WORKING_OP);
  wire is_sleep = (ins == `OP_SLEEP);
  wire is_watchdog_clear_op = (ins == `OP_WATCHDOG_CLEAR_OP);

  // ==========================================================
  // Arithmetic
  // ==========================================================
  logic [8:0] add_sum;
  logic [4:0] add_low;
  logic [8:0] sub_diff;
  logic [4:0] sub_low;
  wire [7:0] add_a = is_lit ? lit : f;
  wire [7:0] sub_a = is_lit ? lit : f;
  assign add_sum = {1'b0, w} + {1'b0, add_a};
  assign add_low = {1'b0, w[3:0]} + {1'b0, add_a[3:0]};
  // Carry means no borrow
  assign sub_diff = {1'b0, sub_a} + {1'b0, ~w} + 9'h001;
  assign sub_low = {1'b0, sub_a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
  wire [7:0] f_dec = f - 8'h01;
  wire [7:0] f_inc = f + 8'h01;
  wire [7:0] bmask = 8'h01 << bsel;
  wire bit_val = |(f & bmask);

  // ==========================================================
  // Result selection
  // ==========================================================
  logic [7:0] res;
  logic wr_w;
  logic wr_f;
  logic set_z;
  logic set_cdc;
  logic set_c;
  logic next_c;
  logic next_dc;
  logic skip;
  always_comb begin
    res = 8'h00;
    wr_w = 1'b0;
    wr_f = 1'b0;
    set_z = 1'b0;
    set_cdc = 1'b0;
    set_c = 1'b0;
    next_c = carry_i;
    next_dc = 1'b0;
    skip = 1'b0;
    if (is_clear_working_op) begin
      res = 8'h00; // see RQ19
      wr_w = 1'b1;
      set_z = 1'b1;
    end else if (is_return_with_literal) begin
      res = lit; // see RQ5
      wr_w = 1'b1;
    end else if (is_lit) begin
      wr_w = 1'b1;
      case (hi)
        `LIT_LOAD_LITERAL_OP: res = lit; // see RQ4
        `LIT_OR_LITERAL_OP: begin
          res = w | lit; // see RQ3
          set_z = 1'b1;
        end
        `LIT_AND_LITERAL_OP: begin
          res = w & lit; // see RQ14
          set_z = 1'b1;
        end
        `LIT_XOR_LITERAL_OP: begin
          res = w ^ lit; // see RQ11
          set_z = 1'b1;
        end
        `LIT_ADD_LITERAL_OP: begin
          res = add_sum[7:0]; // see RQ12
          next_c = add_sum[8];
          next_dc = add_low[4];
          set_z = 1'b1;
          set_cdc = 1'b1;
        end
        `LIT_LITERAL_SUBTRACT_OP: begin
          res = sub_diff[7:0]; // see RQ8
          next_c = sub_diff[8];
          next_dc = sub_low[4];
          set_z = 1'b1;
          set_cdc = 1'b1;
        end
        default: wr_w = 1'b0;
      endcase
    end else if (is_bit) begin
      case (bitop)
        `BIT_CLR: begin
          res = f & ~bmask; // see RQ16
          wr_f = 1'b1;
        end
        `BIT_SET: begin
          res = f | bmask; // see RQ16
          wr_f = 1'b1;
        end
        `BIT_TSC: skip = !bit_val; // see RQ17
        default: skip = bit_val; // see RQ18
      endcase
    end else if (is_byte) begin
      wr_w = !dest;
      wr_f = dest;
      set_z = 1'b1;
      if (ins[11:7] == `BY_MOVWX) begin
        res = w;
        set_z = 1'b0;
      end else if (ins[11:7] == `BY_CLEAR_REGISTER_OP) begin
        res = 8'h00; // see RQ19
      end else begin
        case (bop)
          `BY_ADD: begin
            res = add_sum[7:0]; // see RQ13
            next_c = add_sum[8];
            next_dc = add_low[4];
            set_cdc = 1'b1;
          end
          `BY_SUB: begin
            res = sub_diff[7:0];
            next_c = sub_diff[8];
            next_dc = sub_low[4];
            set_cdc = 1'b1;
          end
          `BY_AND: res = w & f; // see RQ15
          `BY_IOR: res = w | f; // see RQ15
          `BY_XOR: res = w ^ f;
          `BY_MOV: res = f;
          `BY_COM: res = ~f; // see RQ21
          `BY_DEC: res = f_dec; // see RQ22
          `BY_INC: res = f_inc; // see RQ22
          `BY_DECSZ: begin
            res = f_dec; // see RQ23
            set_z = 1'b0;
            skip = (f_dec == 8'h00);
          end
          `BY_INCSZ: begin
            res = f_inc; // see RQ23
            set_z = 1'b0;
            skip = (f_inc == 8'h00);
          end
          `BY_RLX: begin
            res = {f[6:0], carry_i};
            next_c = f[7];
            set_c = 1'b1;
            set_z = 1'b0;
          end
          `BY_RRX: begin
            res = {carry_i, f[7:1]};
            next_c = f[0];
            set_c = 1'b1;
            set_z = 1'b0;
          end
          `BY_SWAP: begin
            res = {f[3:0], f[7:4]};
            set_z = 1'b0;
          end
          default: begin
            wr_w = 1'b0;
            wr_f = 1'b0;
            set_z = 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Sequencing
  // ==========================================================
  wire two_cycle = is_goto || is_call || is_ret || is_interrupt_return || is_return_with_literal;
  wire tab = is_tabl || is_tabh; // see RQ9
  always_comb begin
    next_state = idec_pkg::st_exec;
    case (state)
      idec_pkg::st_exec: begin
        if (tab) begin
          next_state = idec_pkg::st_table;
        end else if (two_cycle || skip) begin
          next_state = idec_pkg::st_flush; // see RQ17
        end
      end
      idec_pkg::st_table: next_state = idec_pkg::st_exec;
      default: next_state = idec_pkg::st_exec;
    endcase
  end
  wire in_table = (state == idec_pkg::st_table);
  wire [7:0] rom_byte = tab_high ? rom_data_i[15:8] : rom_data_i[7:0];
  wire [15:0] tptr = {{(8 - TP_HIGH_W){1'b0}}, table_pointer_high_i,
    table_pointer_low_i}; // see RQ10
  wire [7:0] zsrc = (is_clear_working_op || (is_byte && ins[11:7] == `BY_CLEAR_REGISTER_OP)) ?
    8'h00 : res;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= idec_pkg::st_exec;
      tab_high <= 1'b0;
      w <= 8'h00;
      carry_o <= 1'b0;
      digit_carry_flag_o <= 1'b0;
      zero_o <= 1'b0;
      timeout_flag_o <= 1'b1;
      powerdown_flag_o <= 1'b1;
    end else begin
      state <= next_state;
      if (exec) begin
        tab_high <= is_tabh;
      end
      if (in_table) begin
        w <= rom_byte; // see RQ9
      end else if (wr_w) begin
        w <= res;
      end
      if (set_cdc || set_c) begin
        carry_o <= next_c; // see RQ8
      end
      if (set_cdc) begin
        digit_carry_flag_o <= next_dc; // see RQ12
      end
      if (set_z) begin
        zero_o <= (zsrc == 8'h00); // see RQ3
      end
      if (is_sleep) begin
        timeout_flag_o <= 1'b1; // see RQ7
        powerdown_flag_o <= 1'b0;
      end else if (is_watchdog_clear_op) begin
        timeout_flag_o <= 1'b1; // see RQ20
        powerdown_flag_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      file_addr_o <= 9'h000;
      file_we_o <= 1'b0;
      file_wdata_o <= 8'h00;
      pc_load_o <= 1'b0;
      pc_target_o <= '0;
      push_o <= 1'b0;
      push_data_o <= '0;
      pop_o <= 1'b0;
      global_interrupt_enable_set_o <= 1'b0;
      sleep_req_o <= 1'b0;
      watchdog_clear_o <= 1'b0;
      rom_read_o <= 1'b0;
      rom_addr_o <= 16'h0000;
      busy_o <= 1'b0;
    end else begin
      file_addr_o <= faddr;
      file_we_o <= wr_f;
      file_wdata_o <= res;
      pc_load_o <= is_goto || is_call || is_ret || is_interrupt_return || is_return_with_literal;
      pc_target_o <= (is_goto || is_call) ? {ins[15:14], ins[10:0]} :
        stack_top_i; // see RQ1
      push_o <= is_call; // see RQ2
      push_data_o <= pc_i + 13'h0001;
      pop_o <= is_ret || is_interrupt_return || is_return_with_literal; // see RQ5
      global_interrupt_enable_set_o <= is_interrupt_return; // see RQ6
      sleep_req_o <= is_sleep; // see RQ7
      watchdog_clear_o <= is_watchdog_clear_op; // see RQ20
      rom_read_o <= tab;
      rom_addr_o <= tptr;
      busy_o <= (next_state != idec_pkg::st_exec);
    end
  end

  assign working_o = w;
endmodule

// ===== testbench/far_side_model.sv
`timescale 1ns/10ps
// ==========================================
// Register file and program ROM of the core
module far_side_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] instr_i,
  input wire logic file_we_i,
  input wire logic [8:0] file_addr_i,
  input wire logic [7:0] file_wdata_i,
  input wire logic rom_read_i,
  input wire logic [15:0] rom_addr_i,
  output logic [7:0] file_rdata_o,
  output logic [15:0] rom_data_o
);
  logic [7:0] mem [512];
  logic [8:0] rd_addr;
  logic [15:0] rom_word;
  assign rd_addr = {instr_i[15:14], instr_i[6:0]};
  assign file_rdata_o = mem[rd_addr];
  // ROM word answers while the read strobe stands
  assign rom_word = {rom_addr_i[7:0] ^ 8'h3c, rom_addr_i[11:4]};
  assign rom_data_o = rom_read_i ? rom_word : ~rom_word;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int a = 0; a < 512; a++) mem[a] <= 8'(a) ^ 8'ha5;
    end else begin
      if (file_we_i) mem[file_addr_i] <= file_wdata_i;
    end
  end
endmodule

// ===== testbench/instruction_decoder_asserts.sv
`timescale 1ns/10ps
module instruction_decoder_asserts #(
  parameter int PC_W = 13,
  parameter int TP_HIGH_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] instr_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic [PC_W-1:0] pc_i,
  input wire logic [PC_W-1:0] stack_top_i,
  input wire logic [7:0] table_pointer_low_i,
  input wire logic [TP_HIGH_W-1:0] table_pointer_high_i,
  input wire logic [8:0] file_addr_o,
  input wire logic file_we_o,
  input wire logic [7:0] file_wdata_o,
  input wire logic [7:0] working_o,
  input wire logic carry_o,
  input wire logic zero_o,
  input wire logic pc_load_o,
  input wire logic [PC_W-1:0] pc_target_o,
  input wire logic push_o,
  input wire logic [PC_W-1:0] push_data_o,
  input wire logic pop_o,
  input wire logic global_interrupt_enable_set_o,
  input wire logic sleep_req_o,
  input wire logic timeout_flag_o,
  input wire logic powerdown_flag_o,
  input wire logic rom_read_o,
  input wire logic [15:0] rom_addr_o,
  input wire logic busy_o
);
  // ==========================================
  // Previous-cycle copies
  logic [15:0] p_ins;
  logic [PC_W-1:0] p_pc, p_top;
  logic [7:0] p_fd;
  logic [15:0] p_tp;
  logic [7:0] mask;
  always_ff @(posedge clk_i) begin
    p_ins <= instr_i;
    p_pc <= pc_i;
    p_top <= stack_top_i;
    p_fd <= file_rdata_i;
    p_tp <= 16'({table_pointer_high_i, table_pointer_low_i});
  end
  assign mask = 8'h01 << p_ins[9:7];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Properties
  property p_branch;
    !busy_o && instr_i[13:11] == 3'b101 |=> pc_load_o && busy_o &&
      pc_target_o == {p_ins[15:14], p_ins[10:0]} ##1 !pc_load_o;
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch load wrong");
  property p_call;
    !busy_o && instr_i[13:11] == 3'b100 |=> push_o && pc_load_o &&
      busy_o && push_data_o == PC_W'(p_pc + 1'b1);
  endproperty
  a_call: assert property (p_call)
    else $error("call push wrong");
  property p_return;
    !busy_o && (instr_i & 16'hffdf) == 16'h0040 |=> pop_o && pc_load_o &&
      pc_target_o == p_top && global_interrupt_enable_set_o == p_ins[5];
  endproperty
  a_return: assert property (p_return)
    else $error("return pop wrong");
  property p_load;
    !busy_o && instr_i[15:8] == 8'h19 |=> working_o == p_ins[7:0] &&
      $stable({zero_o, carry_o});
  endproperty
  a_load: assert property (p_load)
    else $error("literal load wrong");
  property p_sleep;
    !busy_o && instr_i == 16'h1e03 |=> sleep_req_o && timeout_flag_o &&
      !powerdown_flag_o;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep request wrong");
  property p_table;
    !busy_o && (instr_i & 16'hfff7) == 16'h0050 |=> rom_read_o && busy_o &&
      rom_addr_o == p_tp;
  endproperty
  a_table: assert property (p_table)
    else $error("table address wrong");
  property p_skip;
    !busy_o && instr_i[13:11] == 3'b111 |=> !pc_load_o &&
      busy_o == (p_fd[p_ins[9:7]] == p_ins[10]);
  endproperty
  a_skip: assert property (p_skip)
    else $error("bit test skip wrong");
  property p_bitw;
    !busy_o && instr_i[13:11] == 3'b110 |=> file_we_o &&
      file_addr_o == {p_ins[15:14], p_ins[6:0]} &&
      file_wdata_o == (p_ins[10] ? p_fd | mask : p_fd & ~mask);
  endproperty
  a_bitw: assert property (p_bitw)
    else $error("bit write wrong");
endmodule
bind instruction_decoder instruction_decoder_asserts
  #(.PC_W(PC_W), .TP_HIGH_W(TP_HIGH_W)) i_chk (.*);

// ===== testbench/instruction_decoder_test.sv
`timescale 1ns/10ps
module instruction_decoder_test;
  typedef struct packed {
    logic [31:0] t;
    logic [2:0] s;
    logic [31:0] v;
  } note_t;
  logic clk_i, rst_i, carry_i;
  logic [15:0] instr_i, rom_data_i, rom_addr_o;
  logic [7:0] file_rdata_i, table_pointer_low_i, file_wdata_o, working_o;
  logic [12:0] pc_i, stack_top_i, pc_target_o, push_data_o, pcv, top_v;
  logic [3:0] table_pointer_high_i;
  logic [8:0] file_addr_o;
  logic file_we_o, carry_o, digit_carry_flag_o, zero_o, pc_load_o, push_o;
  logic pop_o, global_interrupt_enable_set_o, sleep_req_o, watchdog_clear_o;
  logic timeout_flag_o, powerdown_flag_o, rom_read_o, busy_o;
  logic [31:0] cyc, seen;
  logic [7:0] w, lits[6], fm[512];
  logic [3:0] bops[8];
  logic [1:0] bseq[6];
  logic [12:0] k;
  logic [11:0] tpv;
  logic z, c, dcf;
  note_t q[$];
  note_t n;
  integer seed = 32'hef7c4233;
  int miscompares, checks;
  string nm[7] = '{"working", "flags", "write", "control", "power", "push",
    "rom"};
  instruction_decoder #(.PC_W(13), .TP_HIGH_W(4)) i_dut (.*);
  far_side_model i_far (.clk_i, .rst_i, .instr_i, .file_we_i(file_we_o),
    .file_addr_i(file_addr_o), .file_wdata_i(file_wdata_o),
    .rom_read_i(rom_read_o), .rom_addr_i(rom_addr_o),
    .file_rdata_o(file_rdata_i), .rom_data_o(rom_data_i));
  // ==========================================
  // Clock, cycle count, result watcher
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      miscompares++;
      finish_test();
    end
  end
  function automatic logic [31:0] look(input logic [2:0] s);
    case (s)
      3'd0: look = {24'h0, working_o};
      3'd1: look = {29'h0, zero_o, carry_o, digit_carry_flag_o};
      3'd2: look = {14'h0, file_we_o, file_addr_o, file_wdata_o};
      3'd3: look = {14'h0, pc_load_o, push_o, pop_o,
        global_interrupt_enable_set_o, busy_o, pc_target_o};
      3'd4: look = {28'h0, sleep_req_o, watchdog_clear_o, timeout_flag_o,
        powerdown_flag_o};
      3'd5: look = {19'h0, push_data_o};
      default: look = {15'h0, rom_read_o, rom_addr_o};
    endcase
  endfunction
  task automatic check(input logic [2:0] s, input logic [31:0] got,
    input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm[s], exp, got);
    end
  endtask
  always @(negedge clk_i) begin
    while (q.size() > 0 && q[0].t == cyc) begin
      n = q.pop_front();
      seen = look(n.s);
      if (n.s == 3'd3 && !n.v[17]) seen[12:0] = 13'h0;
      check(n.s, seen, n.v);
    end
  end
  // ==========================================
  // Drivers and expectations
  task automatic issue(input logic [15:0] i);
    @(posedge clk_i);
    pcv = 13'($random(seed));
    top_v = 13'($random(seed));
    instr_i <= i;
    pc_i <= pcv;
    stack_top_i <= top_v;
    tpv = 12'($random(seed));
    table_pointer_low_i <= tpv[7:0];
    table_pointer_high_i <= tpv[11:8];
    carry_i <= 1'($random(seed));
  endtask
  task automatic note(input logic [2:0] s, input logic [31:0] v);
    q.push_back({cyc + 32'd2, s, v});
  endtask
  task automatic wf;
    note(3'd0, {24'h0, w});
    note(3'd1, {29'h0, z, c, dcf});
  endtask
  task automatic nxt(input logic skip);
    issue(16'h19ff);
    if (!skip) w = 8'hff;
    wf();
  endtask
  task automatic lit(input logic [7:0] op, input logic [7:0] kv);
    logic [8:0] s;
    issue({op, kv});
    s = w + kv;
    case (op)
      8'h19: w = kv;
      8'h1a: w = w | kv;
      8'h1b: w = w & kv;
      8'h1d: w = w ^ kv;
      8'h1c: begin
        dcf = (w[3:0] + kv[3:0]) > 5'd15;
        c = s[8];
        w = s[7:0];
      end
      default: begin
        dcf = kv[3:0] >= w[3:0];
        c = kv >= w;
        w = kv - w;
      end
    endcase
    if (op != 8'h19) z = (w == 8'h00);
    wf();
  endtask
  task automatic byt(input logic [3:0] op, input logic d, input logic [8:0] f);
    logic [8:0] s;
    logic [7:0] v;
    issue(16'h0000);
    issue({f[8:7], 2'b00, op, d, f[6:0]});
    v = fm[f];
    s = w + v;
    case (op)
      4'h7: begin
        dcf = (w[3:0] + v[3:0]) > 5'd15;
        c = s[8];
      end
      4'h5: s = {1'b0, w & v};
      4'h4: s = {1'b0, w | v};
      4'h9: s = {1'b0, ~v};
      4'h3, 4'hb: s = {1'b0, v - 8'h01};
      4'h1: s = 9'h000;
      default: s = {1'b0, v + 8'h01};
    endcase
    if (op != 4'hb && op != 4'hf) z = (s[7:0] == 8'h00);
    if (d) begin
      fm[f] = s[7:0];
      note(3'd2, {14'h0, 1'b1, f, s[7:0]});
    end else w = s[7:0];
    wf();
    if (op == 4'hb || op == 4'hf) nxt(s[7:0] == 8'h00);
  endtask
  task automatic bop(input logic [1:0] op, input logic [2:0] b,
    input logic [8:0] f);
    logic skip;
    issue(16'h0000);
    issue({f[8:7], 2'b11, op, b, f[6:0]});
    skip = fm[f][b] == op[0];
    if (!op[1]) begin
      fm[f][b] = op[0];
      note(3'd2, {14'h0, 1'b1, f, fm[f]});
      wf();
    end else begin
      note(3'd3, {14'h0, 4'h0, skip, 13'h0});
      nxt(skip);
    end
  endtask
  task automatic ctl(input logic [15:0] i, input logic [4:0] f,
    input logic from_stack);
    issue(i);
    note(3'd3, {14'h0, f, from_stack ? top_v : {i[15:14], i[10:0]}});
    if (f[3]) note(3'd5, {19'h0, pcv + 13'h0001});
    nxt(1'b1);
  endtask
  task automatic tab(input logic hi);
    logic [15:0] a;
    issue({12'h005, hi, 3'b000});
    a = {4'h0, tpv};
    note(3'd6, {15'h0, 1'b1, a});
    issue(16'h0000);
    issue(16'h0000);
    w = hi ? a[7:0] ^ 8'h3c : a[11:4];
    wf();
  endtask
  task finish_test;
    if (q.size() != 0) miscompares++;
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {rst_i, cyc, instr_i, pc_i, stack_top_i, carry_i} = {1'b1, 75'h0};
    {table_pointer_low_i, table_pointer_high_i, w, z, c, dcf} = 23'h0;
    lits = '{8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1f};
    bops = '{4'h7, 4'h5, 4'h4, 4'h9, 4'h3, 4'ha, 4'hb, 4'hf};
    bseq = '{2'd1, 2'd3, 2'd2, 2'd0, 2'd2, 2'd3};
    for (int a = 0; a < 512; a++) fm[a] = 8'(a) ^ 8'ha5;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    issue(16'h0000);
    note(3'd4, 32'h3);
    wf();
    byt(4'hb, 1'b1, 9'h1a4);
    byt(4'hf, 1'b0, 9'h05a);
    foreach (lits[i]) repeat (3) lit(lits[i], 8'($random(seed)));
    lit(8'h1f, w);
    lit(8'h1c, 8'h00 - w);
    for (int i = 0; i < 16; i++) byt(bops[i[2:0]], i[3], 9'($random(seed)));
    byt(4'h1, 1'b1, 9'($random(seed)));
    foreach (bseq[j]) bop(bseq[j], 3'd5, 9'h133);
    k = 13'($random(seed));
    ctl({k[12:11], 3'b101, k[10:0]}, 5'b10001, 1'b0);
    ctl({k[10:9], 3'b100, k[12:2]}, 5'b11001, 1'b0);
    ctl(16'h0040, 5'b10101, 1'b1);
    ctl(16'h0060, 5'b10111, 1'b1);
    w = 8'h3c;
    ctl(16'h183c, 5'b10101, 1'b1);
    issue(16'h1e03);
    note(3'd4, 32'ha);
    issue(16'h1e04);
    note(3'd4, 32'h7);
    issue(16'h0140);
    {w, z} = 9'h001;
    wf();
    tab(1'b0);
    tab(1'b1);
    repeat (4) @(posedge clk_i);
    finish_test();
  end
endmodule
